// ---- shared/ssp_pkg.sv ----
package ssp_pkg;

    // Register byte addresses
    localparam logic [7:0] ADDR_DATA = 8'h00;
    localparam logic [7:0] ADDR_BAUD = 8'h04;
    localparam logic [7:0] ADDR_CTRL = 8'h08;
    localparam logic [7:0] ADDR_IRQ  = 8'h0c;
    localparam logic [7:0] ADDR_PROT = 8'h10;
    localparam logic [7:0] ADDR_PIN  = 8'h14;
    localparam logic [7:0] ADDR_PORT = 8'h18;

    // Serial control fields
    localparam int unsigned CTRL_SRC_LSB  = 0;
    localparam int unsigned CTRL_SRC_MSB  = 1;
    localparam int unsigned CTRL_OUT_FUNC = 2;
    localparam int unsigned CTRL_OUT_EN   = 3;
    localparam int unsigned CTRL_PHASE    = 4;
    localparam int unsigned CTRL_ORDER    = 5;
    localparam int unsigned CTRL_CLK_SRC  = 6;
    localparam int unsigned CTRL_OUT_LVL  = 7;

    // Request control fields
    localparam int unsigned IRQ_LVL_LSB = 0;
    localparam int unsigned IRQ_LVL_MSB = 2;
    localparam int unsigned IRQ_REQ     = 3;
    localparam int unsigned IRQ_CAUSE   = 4;

    // Protect, pin control and port fields
    localparam int unsigned PROT_UNLOCK  = 2;
    localparam int unsigned PIN_SERIAL   = 0;
    localparam int unsigned PIN_CLK_LVL  = 1;
    localparam int unsigned PIN_SOUT_LVL = 2;
    localparam int unsigned PORT_CS      = 0;
    localparam int unsigned PORT_BUSY    = 1;

    // Reset values
    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic [7:0] BAUD_RST = 8'h00;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] IRQ_RST  = 8'h00;
    localparam logic [7:0] PIN_RST  = 8'h06;
    localparam logic       CS_RST   = 1'b1;

    // Last bit index of a byte
    localparam logic [2:0] LAST_BIT = 3'h7;

    typedef enum logic {
        ST_IDLE  = 1'b0,
        ST_SHIFT = 1'b1
    } ssp_state_type;

    // Prescaler terminal count per count source: f1, f8, f32, f2
    function automatic logic [4:0] presc_limit(input logic [1:0] sel);
        logic [4:0] lim;
        lim = 5'h00;
        unique case (sel)
            2'h0: lim = 5'h00;
            2'h1: lim = 5'h07;
            2'h2: lim = 5'h1f;
            2'h3: lim = 5'h01;
        endcase
        return lim;
    endfunction

endpackage

// ---- shared/ssp_baud_if.sv ----
`timescale 1ns/1ps
interface ssp_baud_if;
    logic       run;
    logic [1:0] src;
    logic [7:0] divisor;
    logic       tick;

    modport ctl (output run, output src, output divisor, input tick);
    modport gen (input run, input src, input divisor, output tick);
endinterface

// ---- core/ssp_baud.sv ----
`timescale 1ns/1ps
module ssp_baud (
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Control from the channel
    ssp_baud_if.gen   g
);

    typedef struct packed {
        logic [4:0] pre;
        logic [7:0] div;
        logic       tick;
    } ssp_baud_state_type;

    ssp_baud_state_type r;
    ssp_baud_state_type n;

    // One tick per half transfer-clock period
    always_comb begin
        n = r;
        n.tick = 1'b0;
        if (!g.run) begin
            n.pre = 5'h00;
            n.div = 8'h00;
        end else if (r.pre == ssp_pkg::presc_limit(g.src)) begin
            n.pre = 5'h00;
            if (r.div == g.divisor) begin
                n.div = 8'h00;
                n.tick = 1'b1;
            end else begin
                n.div = r.div + 8'h01;
            end
        end else begin
            n.pre = r.pre + 5'h01;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign g.tick = r.tick;

endmodule

// ---- core/ssp_top.sv ----
// Local design decisions: the APB interface to the registers and the address map.
`timescale 1ns/1ps
// Notes on behaviour
// - Phase zero: launch on fall, sample on rise
// - Order bit one shifts MSB first
// - Transfer clock rests high when idle
// - Data register write while idle starts a transfer
// - Data register: byte in, received byte out
// - Transfer completion sets the request flag when cause is zero
// - Flag one is pending; host clears it
// - Cause one: request when buffer empties
// - Eight-bit divider sets transfer rate
// - Two-bit field picks divider count source
// - Source bit zero: internal clock driven out
// - Data out needs function 0, enable 1
// - Protected registers need unlock just before
module ssp_top (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Transfer clock pin
    output logic             clk_o,
    output logic             clk_oe,
    input  wire logic        clk_i,
    // Serial data pins
    output logic             sout_o,
    output logic             sout_oe,
    input  wire logic        sin_i,
    // Chip select port
    output logic             cs_n_o
);

    typedef struct packed {
        ssp_pkg::ssp_state_type st;
        logic [7:0]             shreg;
        logic [7:0]             baud;
        logic [7:0]             ctrl;
        logic [7:0]             irq;
        logic [7:0]             pin;
        logic                   cs;
        logic                   unlock;
        logic [2:0]             bit_cnt;
        logic                   sclk;
        logic                   sout;
        logic                   clk_pin;
        logic                   clk_oe;
        logic                   sout_pin;
        logic                   sout_oe;
        logic                   clk_in_d;
        logic                   pready;
        logic                   pslverr;
        logic [31:0]            prdata;
    } ssp_top_state_type;

    ssp_top_state_type r;
    ssp_top_state_type n;

    ssp_baud_if bif ();

    ssp_baud u_baud (
        .pclk    (pclk),
        .presetn (presetn),
        .g       (bif)
    );

    function automatic logic out_bit(input logic [7:0] d, input logic msb_first);
        return msb_first ? d[7] : d[0];
    endfunction

    function automatic logic [7:0] shift_in(input logic [7:0] d, input logic msb_first, input logic b);
        return msb_first ? {d[6:0], b} : {b, d[7:1]};
    endfunction

    function automatic logic addr_mapped(input logic [7:0] a);
        return a == ssp_pkg::ADDR_DATA || a == ssp_pkg::ADDR_BAUD ||
               a == ssp_pkg::ADDR_CTRL || a == ssp_pkg::ADDR_IRQ  ||
               a == ssp_pkg::ADDR_PROT || a == ssp_pkg::ADDR_PIN  ||
               a == ssp_pkg::ADDR_PORT;
    endfunction

    logic setup;
    logic wr;
    logic start;
    logic set_req;
    logic fall_ev;
    logic rise_ev;
    logic ext_clk;
    logic msb_first;
    logic phase;
    logic serial_pins;
    logic [7:0] rd_byte;

    always_comb begin
        n = r;
        n.pready = 1'b0;
        n.pslverr = 1'b0;
        start = 1'b0;
        set_req = 1'b0;
        rd_byte = 8'h00;
        ext_clk = r.ctrl[ssp_pkg::CTRL_CLK_SRC];
        msb_first = r.ctrl[ssp_pkg::CTRL_ORDER];
        phase = r.ctrl[ssp_pkg::CTRL_PHASE];
        // A cycle that already answers is never taken as a new setup
        setup = psel && !penable && !r.pready;
        wr = psel && penable && r.pready && pwrite;

        // Clock edges come from the divider, or from the pin in slave mode
        if (ext_clk) begin
            fall_ev = r.clk_in_d && !clk_i;
            rise_ev = !r.clk_in_d && clk_i;
        end else begin
            fall_ev = bif.tick && r.sclk;
            rise_ev = bif.tick && !r.sclk;
        end

        // Read data is captured in the setup cycle, answered in the access
        if (setup) begin
            n.pready = 1'b1;
            n.pslverr = !addr_mapped(paddr);
            case (paddr)
                ssp_pkg::ADDR_DATA: begin
                    rd_byte = r.shreg;
                end
                ssp_pkg::ADDR_BAUD: begin
                    rd_byte = r.baud;
                end
                ssp_pkg::ADDR_CTRL: begin
                    rd_byte = r.ctrl;
                end
                ssp_pkg::ADDR_IRQ: begin
                    rd_byte = r.irq;
                end
                ssp_pkg::ADDR_PROT: begin
                    rd_byte[ssp_pkg::PROT_UNLOCK] = r.unlock;
                end
                ssp_pkg::ADDR_PIN: begin
                    rd_byte = r.pin;
                end
                ssp_pkg::ADDR_PORT: begin
                    rd_byte[ssp_pkg::PORT_CS] = r.cs;
                    rd_byte[ssp_pkg::PORT_BUSY] = r.st == ssp_pkg::ST_SHIFT;
                end
                default: begin
                    rd_byte = 8'h00;
                end
            endcase
            n.prdata = {24'h000000, rd_byte};
        end

        // Any write other than to the protect register uses up the unlock
        if (wr) begin
            n.unlock = 1'b0;
            case (paddr)
                ssp_pkg::ADDR_DATA: begin
                    start = r.st == ssp_pkg::ST_IDLE;
                end
                ssp_pkg::ADDR_BAUD: begin
                    n.baud = pwdata[7:0];
                end
                ssp_pkg::ADDR_CTRL: begin
                    if (r.unlock) begin
                        n.ctrl = pwdata[7:0];
                    end
                end
                ssp_pkg::ADDR_IRQ: begin
                    n.irq = pwdata[7:0];
                end
                ssp_pkg::ADDR_PROT: begin
                    n.unlock = pwdata[ssp_pkg::PROT_UNLOCK];
                end
                ssp_pkg::ADDR_PIN: begin
                    if (r.unlock) begin
                        n.pin = pwdata[7:0];
                    end
                end
                ssp_pkg::ADDR_PORT: begin
                    n.cs = pwdata[ssp_pkg::PORT_CS];
                end
                default: begin
                    n.unlock = 1'b0;
                end
            endcase
        end

        // Shifter: eight clock periods, then back to idle
        unique case (r.st)
            ssp_pkg::ST_IDLE: begin
                n.sclk = 1'b1;
                n.bit_cnt = 3'h0;
                if (start) begin
                    n.st = ssp_pkg::ST_SHIFT;
                    n.shreg = pwdata[7:0];
                    // Phase zero keeps the idle level until the first fall
                    if (phase) begin
                        n.sout = out_bit(pwdata[7:0], msb_first);
                    end else begin
                        n.sout = r.ctrl[ssp_pkg::CTRL_OUT_LVL];
                    end
                    set_req = r.irq[ssp_pkg::IRQ_CAUSE];
                end else begin
                    n.sout = r.ctrl[ssp_pkg::CTRL_OUT_LVL];
                end
            end
            ssp_pkg::ST_SHIFT: begin
                if (fall_ev) begin
                    n.sclk = 1'b0;
                    if (!phase) begin
                        n.sout = out_bit(r.shreg, msb_first);
                    end else begin
                        n.shreg = shift_in(r.shreg, msb_first, sin_i);
                    end
                end
                if (rise_ev) begin
                    n.sclk = 1'b1;
                    if (!phase) begin
                        n.shreg = shift_in(r.shreg, msb_first, sin_i);
                    end
                    if (r.bit_cnt == ssp_pkg::LAST_BIT) begin
                        n.st = ssp_pkg::ST_IDLE;
                        set_req = !r.irq[ssp_pkg::IRQ_CAUSE];
                    end else begin
                        n.bit_cnt = r.bit_cnt + 3'h1;
                        if (phase) begin
                            n.sout = out_bit(r.shreg, msb_first);
                        end
                    end
                end
            end
        endcase

        // Hardware set wins over a clearing write in the same cycle
        if (set_req) begin
            n.irq[ssp_pkg::IRQ_REQ] = 1'b1;
        end

        // Pins follow the next state so they change with it
        serial_pins = n.pin[ssp_pkg::PIN_SERIAL];
        if (serial_pins) begin
            n.clk_pin = n.sclk;
            n.clk_oe = !n.ctrl[ssp_pkg::CTRL_CLK_SRC];
            n.sout_pin = n.sout;
            n.sout_oe = !n.ctrl[ssp_pkg::CTRL_OUT_FUNC] && n.ctrl[ssp_pkg::CTRL_OUT_EN];
        end else begin
            n.clk_pin = n.pin[ssp_pkg::PIN_CLK_LVL];
            n.clk_oe = 1'b1;
            n.sout_pin = n.pin[ssp_pkg::PIN_SOUT_LVL];
            n.sout_oe = 1'b1;
        end
        // Pin level one cycle back, for edges in slave mode
        n.clk_in_d = clk_i;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '{
                st:       ssp_pkg::ST_IDLE,
                shreg:    ssp_pkg::DATA_RST,
                baud:     ssp_pkg::BAUD_RST,
                ctrl:     ssp_pkg::CTRL_RST,
                irq:      ssp_pkg::IRQ_RST,
                pin:      ssp_pkg::PIN_RST,
                cs:       ssp_pkg::CS_RST,
                unlock:   1'b0,
                bit_cnt:  3'h0,
                sclk:     1'b1,
                sout:     1'b0,
                clk_pin:  1'b1,
                clk_oe:   1'b1,
                sout_pin: 1'b1,
                sout_oe:  1'b1,
                clk_in_d: 1'b1,
                pready:   1'b0,
                pslverr:  1'b0,
                prdata:   32'h00000000
            };
        end else begin
            r <= n;
        end
    end

    // Divider runs only while shifting on the internal clock
    assign bif.run = (r.st == ssp_pkg::ST_SHIFT) && !r.ctrl[ssp_pkg::CTRL_CLK_SRC];
    assign bif.src = r.ctrl[ssp_pkg::CTRL_SRC_MSB:ssp_pkg::CTRL_SRC_LSB];
    assign bif.divisor = r.baud;

    assign prdata = r.prdata;
    assign pready = r.pready;
    assign pslverr = r.pslverr;
    assign clk_o = r.clk_pin;
    assign clk_oe = r.clk_oe;
    assign sout_o = r.sout_pin;
    assign sout_oe = r.sout_oe;
    assign cs_n_o = r.cs;

endmodule

// ---- bench/ssp_sva.sv ----
`timescale 1ns/1ps
module ssp_sva (
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // APB
    input wire logic [7:0]  paddr,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Pins
    input wire logic        clk_o,
    input wire logic        clk_oe,
    input wire logic        clk_i,
    input wire logic        sout_o,
    input wire logic        sout_oe,
    input wire logic        sin_i,
    input wire logic        cs_n_o
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [3:0] rcnt_r;
    wire        wr_data = psel && penable && pwrite && pready && paddr == ssp_pkg::ADDR_DATA;
    // Clock rises since the last data write, held at eight
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rcnt_r <= 4'h8;
        end else if (wr_data) begin
            rcnt_r <= 4'h0;
        end else if ($rose(clk_o) && rcnt_r != 4'h8) begin
            rcnt_r <= rcnt_r + 4'h1;
        end
    end
    property p_answer;
        psel && !penable |=> pready;
    endproperty
    a_answer: assert property (p_answer) else $error("no ready in access");
    property p_pulse;
        pready |=> !pready;
    endproperty
    a_pulse: assert property (p_pulse) else $error("ready too long");
    property p_err;
        pslverr |-> pready;
    endproperty
    a_err: assert property (p_err) else $error("error without ready");
    property p_rd_hi;
        pready |-> prdata[31:8] == 24'h0;
    endproperty
    a_rd_hi: assert property (p_rd_hi) else $error("upper read bits set");
    property p_clk_drv;
        clk_oe;
    endproperty
    a_clk_drv: assert property (p_clk_drv) else $error("clock not driven");
    property p_sout_drv;
        sout_oe;
    endproperty
    a_sout_drv: assert property (p_sout_drv) else $error("data out not driven");
    property p_launch;
        $rose(clk_o) && rcnt_r < 4'h7 |-> $stable(sout_o);
    endproperty
    a_launch: assert property (p_launch) else $error("data moved on rise");
    property p_hold;
        rcnt_r < 4'h8 && !$fell(clk_o) |-> $stable(sout_o);
    endproperty
    a_hold: assert property (p_hold) else $error("data moved off a falling edge");
    property p_idle;
        rcnt_r == 4'h8 |-> clk_o;
    endproperty
    a_idle: assert property (p_idle) else $error("clock low when idle");
    property p_eight;
        $rose(clk_o) |-> rcnt_r < 4'h8;
    endproperty
    a_eight: assert property (p_eight) else $error("ninth clock");
    property p_start;
        wr_data |-> ##[1:600] $fell(clk_o);
    endproperty
    a_start: assert property (p_start) else $error("write did not start");
    property p_done;
        wr_data |-> ##[16:1000] rcnt_r == 4'h8;
    endproperty
    a_done: assert property (p_done) else $error("eight clocks missing");
    c_xfer: cover property (wr_data ##[16:1000] rcnt_r == 4'h8);
    c_err: cover property (pslverr);
    c_sel: cover property ($fell(cs_n_o));
endmodule
bind ssp_top ssp_sva u_sva (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .clk_o(clk_o),
    .clk_oe(clk_oe), .clk_i(clk_i), .sout_o(sout_o), .sout_oe(sout_oe), .sin_i(sin_i), .cs_n_o(cs_n_o));

// ---- bench/ssp_eep_model.sv ----
`timescale 1ns/1ps
module ssp_eep_model (
    // Memory pins
    input wire logic       sck_i,
    input wire logic       si_i,
    input wire logic       cs_n_i,
    output logic           so_o,
    // Bench side
    input wire logic [7:0] reply_i,
    output logic     [7:0] got_o
);
    logic [2:0] idx = 3'h7;
    initial so_o = 1'b1;
    initial got_o = 8'h00;
    always @(negedge cs_n_i) idx = 3'h7;
    always @(negedge sck_i) begin
        if (!cs_n_i) begin
            so_o <= reply_i[idx];
        end
    end
    always @(posedge sck_i) begin
        if (!cs_n_i) begin
            got_o <= {got_o[6:0], si_i};
            idx = idx - 3'h1;
        end
    end
    // Released output holds no valid level
    always @(posedge cs_n_i) so_o <= ~so_o;
endmodule

// ---- bench/sync_serial_eeprom_port_tb_top.sv ----
`timescale 1ns/1ps
module sync_serial_eeprom_port_tb_top;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready, pslverr, clk_o, clk_oe, sout_o, sout_oe, cs_n_o, so, e, clk_q = 1'b1;
    logic [31:0] r;
    logic [7:0]  reply = 8'h00;
    logic [7:0]  got;
    int          n_mismatch = 0;
    int          samples_checked = 0;
    int          cyc = 0;
    int          since = 0;
    int          period = 0;
    wire         clk_pin = clk_oe ? clk_o : 1'b1;
    wire         sout_pin = sout_oe ? sout_o : 1'b1;
    logic [7:0]  radr [7] = '{ssp_pkg::ADDR_DATA, ssp_pkg::ADDR_BAUD, ssp_pkg::ADDR_CTRL,
                              ssp_pkg::ADDR_IRQ, ssp_pkg::ADDR_PIN, ssp_pkg::ADDR_PORT, 8'h1c};
    logic [7:0]  rval [7] = '{ssp_pkg::DATA_RST, ssp_pkg::BAUD_RST, ssp_pkg::CTRL_RST,
                              ssp_pkg::IRQ_RST, ssp_pkg::PIN_RST, {7'h0, ssp_pkg::CS_RST}, 8'h00};
    logic [7:0]  txv [4] = '{8'h1d, 8'hff, 8'h80, 8'h35};
    logic [7:0]  rxv [4] = '{8'hb4, 8'h5a, 8'h01, 8'hc6};
    int          div [4] = '{1, 8, 32, 2};

    always #10 pclk = ~pclk;

    ssp_top dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .clk_o(clk_o), .clk_oe(clk_oe), .clk_i(clk_pin), .sout_o(sout_o), .sout_oe(sout_oe),
        .sin_i(so), .cs_n_o(cs_n_o));
    ssp_eep_model mem (.sck_i(clk_pin), .si_i(sout_pin), .cs_n_i(cs_n_o), .so_o(so), .reply_i(reply),
        .got_o(got));

    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] gv, input logic [31:0] ev);
        samples_checked++;
        if (gv !== ev) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got %h exp %h", $time, gv, ev);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Protected write: unlock, then the write at once
    task automatic wp(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, ssp_pkg::ADDR_PROT, 8'h04);
        apb(1'b1, a, d);
    endtask

    task automatic xfer(input logic [7:0] tx, input logic [7:0] rx, input int half);
        int n;
        n = 0;
        reply = rx;
        apb(1'b1, ssp_pkg::ADDR_DATA, tx);
        apb(1'b0, ssp_pkg::ADDR_IRQ, 8'h00);
        chk({31'h0, r[3]}, 32'h0);
        do begin
            apb(1'b0, ssp_pkg::ADDR_IRQ, 8'h00);
            n++;
        end while (r[3] !== 1'b1 && n < 400);
        chk({31'h0, r[3]}, 32'h1);
        chk({24'h0, got}, {24'h0, tx});
        chk(period, 2 * half);
        apb(1'b0, ssp_pkg::ADDR_DATA, 8'h00);
        chk(r, {24'h0, rx});
        apb(1'b1, ssp_pkg::ADDR_IRQ, 8'h00);
        apb(1'b0, ssp_pkg::ADDR_IRQ, 8'h00);
        chk(r, 32'h0);
    endtask

    // Cycles between falling transfer-clock edges, and the hang limit
    always @(posedge pclk) begin
        cyc++;
        clk_q <= clk_o;
        if (clk_q && !clk_o) begin
            period <= since;
            since  <= 1;
        end else begin
            since <= since + 1;
        end
        if (cyc == 30000) begin
            n_mismatch++;
            summarize();
        end
    end

    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        foreach (radr[i]) begin
            apb(1'b0, radr[i], 8'h00);
            chk(r, {24'h0, rval[i]});
        end
        chk({31'h0, e}, 32'h1);
        apb(1'b1, ssp_pkg::ADDR_PORT, 8'h01);
        wp(ssp_pkg::ADDR_CTRL, 8'ha8);
        apb(1'b1, ssp_pkg::ADDR_IRQ, 8'h00);
        wp(ssp_pkg::ADDR_PIN, 8'h07);
        apb(1'b1, ssp_pkg::ADDR_PROT, 8'h04);
        apb(1'b1, ssp_pkg::ADDR_BAUD, 8'h00);
        apb(1'b1, ssp_pkg::ADDR_CTRL, 8'h00);
        apb(1'b0, ssp_pkg::ADDR_CTRL, 8'h00);
        chk(r, 32'ha8);
        apb(1'b1, ssp_pkg::ADDR_PORT, 8'h00);
        @(posedge pclk);
        chk({31'h0, cs_n_o}, 32'h0);
        repeat (4) @(posedge pclk);
        for (int s = 0; s < 4; s++) begin
            wp(ssp_pkg::ADDR_CTRL, 8'ha8 + s[7:0]);
            xfer(txv[s], rxv[s], div[s]);
        end
        // Cause one raises the flag at start; a data write while busy is ignored
        apb(1'b1, ssp_pkg::ADDR_IRQ, 8'h10);
        apb(1'b1, ssp_pkg::ADDR_DATA, 8'h5a);
        apb(1'b1, ssp_pkg::ADDR_DATA, 8'h00);
        apb(1'b0, ssp_pkg::ADDR_IRQ, 8'h00);
        chk(r, 32'h18);
        do apb(1'b0, ssp_pkg::ADDR_PORT, 8'h00); while (r[1] !== 1'b0);
        chk({24'h0, got}, 32'h5a);
        apb(1'b0, ssp_pkg::ADDR_DATA, 8'h00);
        chk(r, {24'h0, rxv[3]});
        apb(1'b1, ssp_pkg::ADDR_IRQ, 8'h00);
        wp(ssp_pkg::ADDR_CTRL, 8'ha8);
        apb(1'b1, ssp_pkg::ADDR_BAUD, 8'h02);
        xfer(8'h3c, 8'h96, 3);
        repeat (4) @(posedge pclk);
        apb(1'b1, ssp_pkg::ADDR_PORT, 8'h01);
        wp(ssp_pkg::ADDR_PIN, 8'h06);
        @(posedge pclk);
        chk({30'h0, cs_n_o, clk_o}, 32'h3);
        summarize();
    end
endmodule
